// File: dct_pkg.sv
`default_nettype none

package dct_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PRE_W = 8;
  localparam int IRQ_N = 4;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RCA = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RCB = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CNT1 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CNT2 = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PRESC = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_ISTAT = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_IMASK = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h24;

  // ---------------------------------------------------------------
  // field positions and values
  // ---------------------------------------------------------------
  localparam int IRQ_A = 0;
  localparam int IRQ_B = 1;
  localparam int IRQ_C = 2;
  localparam int IRQ_D = 3;
  localparam int CMD_START = 0;
  localparam logic [CNT_W-1:0] PRESET_VAL = 16'hFFFF;

  typedef enum logic [2:0] {
    MODE_ALT = 3'b000,
    MODE_TRAIN = 3'b001,
    MODE_DCAP = 3'b010,
    MODE_DUAL = 3'b011,
    MODE_CAPT = 3'b100
  } dct_mode_t;

  typedef enum logic [1:0] {
    CK_OFF = 2'b00,
    CK_CPU = 2'b01,
    CK_PRE = 2'b10,
    CK_EXT = 2'b11
  } dct_clk_t;

  typedef enum logic [1:0] {
    TR_SW = 2'b00,
    TR_RISE = 2'b01,
    TR_FALL = 2'b10,
    TR_NONE = 2'b11
  } dct_trig_t;

  typedef struct packed {
    logic [14:0] rsvd;
    logic pin_a_en;
    logic run2;
    logic run1;
    logic [1:0] trig;
    logic preset_b;
    logic preset_a;
    logic edge_b_rise;
    logic edge_a_rise;
    logic ext_rise;
    logic [1:0] clk2;
    logic [1:0] clk1;
    logic [2:0] mode;
  } dct_ctrl_t;

  typedef struct packed {
    logic [1:0] a_sync;
    logic [1:0] b_sync;
    logic [1:0] t_sync;
    logic a_prev;
    logic b_prev;
    logic t_prev;
    dct_ctrl_t ctrl;
    logic [CNT_W-1:0] cnt1;
    logic [CNT_W-1:0] cnt2;
    logic [CNT_W-1:0] rca;
    logic [CNT_W-1:0] rcb;
    logic [PRE_W-1:0] pre_div;
    logic [PRE_W-1:0] pre_cnt;
    logic [IRQ_N-1:0] istat;
    logic [IRQ_N-1:0] imask;
    logic phase;
    logic train_on;
    logic pin_a;
    logic [DATA_W-1:0] rdata;
  } dct_state_t;

  // timer pins idle high, so their edge detectors start high: no false edge after reset
  localparam dct_state_t STATE_RST = '{a_sync: 2'h3, b_sync: 2'h3, a_prev: 1'h1, b_prev: 1'h1,
                                       default: '0};

endpackage

`default_nettype wire

// File: dct_timer.sv
// Behaviour
// - alternate mode: counter one decrements on chosen clock
// - underflow reloads alternately A then B
// - reload raises separately enabled interrupt
// - counter two decrements, interrupts on underflow
// - pulse train stops after programmed pulse count
// - train starts on software or chosen edge
// - pin edges capture counter one into A/B
// - per input edge select and optional preset
// - dual capture: captures raise interrupts A, B
// - dual capture: counter one underflow raises C
// - dual mode: independent counters, square wave A
// - pin B usable as event clock input
// - clock selector: cpu, prescaled, pin B edge
// - dual mode: underflows raise interrupts A, D
// - capture plus timer: counter two captures pin B
// - capture plus timer: interrupts B, A, D
// - counter two presets on capture when enabled
`timescale 1ns/1ps
`default_nettype none

module dct_timer
  import dct_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic pin_a_in,
  input wire logic pin_b_in,
  input wire logic trig_in,
  output logic pin_a_out,
  output logic pin_a_oe_n,
  output logic irq
);

  dct_state_t s;
  dct_state_t n;
  logic [IRQ_N-1:0] ev;
  logic [IRQ_N-1:0] clr;
  logic a_rise, a_fall, b_rise, b_fall, t_rise, t_fall;
  logic ext_ev, cap_a, cap_b, pre_tick, in_train;
  logic tick1, tick2, uf1, uf2, sw_start, start;

  // ---------------------------------------------------------------
  // clock selection
  // ---------------------------------------------------------------
  function automatic logic sel_tick(input logic [1:0] sel, input logic pre,
                                    input logic ext);
    logic t;
    t = 1'b0;
    unique case (sel)
      CK_OFF: t = 1'b0;
      CK_CPU: t = 1'b1;
      CK_PRE: t = pre;
      CK_EXT: t = ext;
    endcase
    return t;
  endfunction

  // ---------------------------------------------------------------
  // edge and event decode
  // ---------------------------------------------------------------
  assign a_rise = s.a_sync[1] & ~s.a_prev;
  assign a_fall = ~s.a_sync[1] & s.a_prev;
  assign b_rise = s.b_sync[1] & ~s.b_prev;
  assign b_fall = ~s.b_sync[1] & s.b_prev;
  assign t_rise = s.t_sync[1] & ~s.t_prev;
  assign t_fall = ~s.t_sync[1] & s.t_prev;
  assign ext_ev = s.ctrl.ext_rise ? b_rise : b_fall;
  assign cap_a = s.ctrl.edge_a_rise ? a_rise : a_fall;
  assign cap_b = s.ctrl.edge_b_rise ? b_rise : b_fall;
  assign pre_tick = (s.pre_cnt == '0);
  assign in_train = (s.ctrl.mode == MODE_TRAIN);
  assign tick1 = sel_tick(s.ctrl.clk1, pre_tick, ext_ev) &
                 (in_train ? s.train_on : s.ctrl.run1);
  assign tick2 = sel_tick(s.ctrl.clk2, pre_tick, ext_ev) &
                 s.ctrl.run2 & ~in_train;
  assign uf1 = tick1 & (s.cnt1 == '0);
  assign uf2 = tick2 & (s.cnt2 == '0);
  assign sw_start = reg_wr & (reg_addr == OFS_CMD) & reg_wdata[CMD_START];
  assign start = in_train & ~s.train_on &
                 ((s.ctrl.trig == TR_SW) ? sw_start :
                  (s.ctrl.trig == TR_RISE) ? t_rise :
                  (s.ctrl.trig == TR_FALL) ? t_fall : 1'b0);
  assign clr = (reg_wr && reg_addr == OFS_ISTAT) ? reg_wdata[IRQ_N-1:0] : '0;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    n = s;
    ev = '0;
    n.a_sync = {s.a_sync[0], pin_a_in};
    n.b_sync = {s.b_sync[0], pin_b_in};
    n.t_sync = {s.t_sync[0], trig_in};
    n.a_prev = s.a_sync[1];
    n.b_prev = s.b_sync[1];
    n.t_prev = s.t_sync[1];
    n.pre_cnt = pre_tick ? s.pre_div : s.pre_cnt - 1'b1;
    // free decrement, wraps to all ones on underflow
    if (tick1) begin
      n.cnt1 = s.cnt1 - 1'b1;
    end
    if (tick2) begin
      n.cnt2 = s.cnt2 - 1'b1;
    end
    // register read, answered next cycle
    n.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: n.rdata = s.ctrl;
        OFS_RCA: n.rdata = DATA_W'(s.rca);
        OFS_RCB: n.rdata = DATA_W'(s.rcb);
        OFS_CNT1: n.rdata = DATA_W'(s.cnt1);
        OFS_CNT2: n.rdata = DATA_W'(s.cnt2);
        OFS_PRESC: n.rdata = DATA_W'(s.pre_div);
        OFS_ISTAT: n.rdata = DATA_W'(s.istat);
        OFS_IMASK: n.rdata = DATA_W'(s.imask);
        OFS_STAT: n.rdata = DATA_W'({s.train_on, s.phase, s.pin_a});
        default: n.rdata = '0;
      endcase
    end
    // register write; hardware events below take precedence
    if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL: begin
          n.ctrl = dct_ctrl_t'(reg_wdata);
          n.ctrl.rsvd = '0;
        end
        OFS_RCA: n.rca = reg_wdata[CNT_W-1:0];
        OFS_RCB: n.rcb = reg_wdata[CNT_W-1:0];
        OFS_CNT1: n.cnt1 = reg_wdata[CNT_W-1:0];
        OFS_CNT2: n.cnt2 = reg_wdata[CNT_W-1:0];
        OFS_PRESC: n.pre_div = reg_wdata[PRE_W-1:0];
        OFS_IMASK: n.imask = reg_wdata[IRQ_N-1:0];
        default: ;
      endcase
    end
    // mode behaviour
    unique case (s.ctrl.mode)
      MODE_ALT: begin
        if (uf1) begin
          n.cnt1 = s.phase ? s.rcb : s.rca;
          n.phase = ~s.phase;
          n.pin_a = ~s.phase;
          ev[s.phase ? IRQ_B : IRQ_A] = 1'b1;
        end
        if (uf2) begin
          ev[IRQ_D] = 1'b1;
        end
      end
      MODE_TRAIN: begin
        if (start) begin
          n.train_on = 1'b1;
          n.cnt1 = s.rca;
          n.phase = 1'b1;
          n.pin_a = 1'b1;
          ev[IRQ_A] = 1'b1;
        end else if (uf1 && s.phase) begin
          n.cnt1 = s.rcb;
          n.phase = 1'b0;
          n.pin_a = 1'b0;
          ev[IRQ_B] = 1'b1;
        end else if (uf1) begin
          if (s.cnt2 <= CNT_W'(1)) begin
            n.train_on = 1'b0;
            n.cnt2 = '0;
            ev[IRQ_D] = 1'b1;
          end else begin
            n.cnt2 = s.cnt2 - 1'b1;
            n.cnt1 = s.rca;
            n.phase = 1'b1;
            n.pin_a = 1'b1;
            ev[IRQ_A] = 1'b1;
          end
        end
      end
      MODE_DCAP: begin
        if (cap_a) begin
          n.rca = s.cnt1;
          if (s.ctrl.preset_a) begin
            n.cnt1 = PRESET_VAL;
          end
          ev[IRQ_A] = 1'b1;
        end
        if (cap_b) begin
          n.rcb = s.cnt1;
          if (s.ctrl.preset_b) begin
            n.cnt1 = PRESET_VAL;
          end
          ev[IRQ_B] = 1'b1;
        end
        if (uf1) begin
          ev[IRQ_C] = 1'b1;
        end
        if (uf2) begin
          ev[IRQ_D] = 1'b1;
        end
      end
      MODE_DUAL: begin
        if (uf1) begin
          n.cnt1 = s.rca;
          n.pin_a = ~s.pin_a;
          ev[IRQ_A] = 1'b1;
        end
        if (uf2) begin
          n.cnt2 = s.rcb;
          ev[IRQ_D] = 1'b1;
        end
      end
      MODE_CAPT: begin
        if (uf1) begin
          n.cnt1 = s.rca;
          n.pin_a = ~s.pin_a;
          ev[IRQ_A] = 1'b1;
        end
        if (cap_b) begin
          n.rcb = s.cnt2;
          if (s.ctrl.preset_b) begin
            n.cnt2 = PRESET_VAL;
          end
          ev[IRQ_B] = 1'b1;
        end
        if (uf2) begin
          ev[IRQ_D] = 1'b1;
        end
      end
      default: ;
    endcase
    // set wins over a write-one clear
    n.istat = (s.istat & ~clr) | ev;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= STATE_RST;
    end else begin
      s <= n;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata = s.rdata;
  assign pin_a_out = s.pin_a;
  assign pin_a_oe_n = ~(s.ctrl.pin_a_en & (s.ctrl.mode != MODE_DCAP));
  assign irq = |(s.istat & s.imask);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_cnt1_dec: assert property (
    (s.ctrl.mode == MODE_ALT) && tick1 && !uf1 && !reg_wr
    |=> s.cnt1 == $past(s.cnt1) - 1'b1)
    else $error("counter one did not decrement");

  a_alt_reload: assert property (
    (s.ctrl.mode == MODE_ALT) && uf1
    |=> (s.cnt1 == ($past(s.phase) ? $past(s.rcb) : $past(s.rca)))
        && (s.phase != $past(s.phase)))
    else $error("alternate reload wrong");

  a_reload_irq: assert property (
    (s.ctrl.mode == MODE_ALT) && uf1 && !s.phase |=> s.istat[IRQ_A])
    else $error("reload did not flag");

  a_cnt2_flag: assert property (
    uf2 && (s.ctrl.mode inside {MODE_ALT, MODE_DCAP, MODE_DUAL, MODE_CAPT})
    |=> s.istat[IRQ_D])
    else $error("counter two underflow not flagged");

  a_train_stop: assert property (
    in_train && s.train_on && uf1 && !s.phase && (s.cnt2 <= CNT_W'(1))
    |=> !s.train_on && s.istat[IRQ_D] && !s.pin_a)
    else $error("pulse train did not stop");

  a_train_start: assert property (
    start |=> s.train_on && s.pin_a && (s.cnt1 == $past(s.rca)))
    else $error("pulse train did not start");

  a_capture_a: assert property (
    (s.ctrl.mode == MODE_DCAP) && cap_a |=> s.rca == $past(s.cnt1))
    else $error("capture A lost");

  a_capture_preset: assert property (
    (s.ctrl.mode == MODE_DCAP) && cap_b && s.ctrl.preset_b
    |=> s.cnt1 == PRESET_VAL)
    else $error("capture preset missing");

  a_dcap_irq: assert property (
    (s.ctrl.mode == MODE_DCAP) && cap_b |=> s.istat[IRQ_B])
    else $error("capture B not flagged");

  a_dcap_uflow: assert property (
    (s.ctrl.mode == MODE_DCAP) && uf1 |=> s.istat[IRQ_C])
    else $error("underflow C not flagged");

  a_dual_square: assert property (
    (s.ctrl.mode == MODE_DUAL) && uf1
    |=> (s.pin_a != $past(s.pin_a)) && s.istat[IRQ_A])
    else $error("square wave did not toggle");

  a_capt_capture: assert property (
    (s.ctrl.mode == MODE_CAPT) && cap_b && s.ctrl.preset_b
    |=> (s.rcb == $past(s.cnt2)) && (s.cnt2 == PRESET_VAL) && s.istat[IRQ_B])
    else $error("capture plus timer capture wrong");

  a_capture_preset_a: assert property (
    (s.ctrl.mode == MODE_DCAP) && cap_a && s.ctrl.preset_a
    |=> s.cnt1 == PRESET_VAL)
    else $error("capture preset A missing");

  a_dual_uflow: assert property (
    (s.ctrl.mode == MODE_DUAL) && uf2 |=> (s.cnt2 == $past(s.rcb)) && s.istat[IRQ_D])
    else $error("counter two reload not flagged");

  a_capt_uflow: assert property (
    (s.ctrl.mode == MODE_CAPT) && uf1 |=> (s.cnt1 == $past(s.rca)) && s.istat[IRQ_A])
    else $error("timer underflow not flagged");

  a_flag_sticky: assert property (
    s.istat[IRQ_A] && !(reg_wr && reg_addr == OFS_ISTAT) |=> s.istat[IRQ_A])
    else $error("pending flag dropped");

  c_train_done: cover property (s.train_on ##1 !s.train_on);
  c_alt_reload_b: cover property ((s.ctrl.mode == MODE_ALT) && uf1 && s.phase);
  c_capture_b: cover property ((s.ctrl.mode == MODE_CAPT) && cap_b);
  c_dcap_capture_a: cover property ((s.ctrl.mode == MODE_DCAP) && cap_a);
  c_irq_raise: cover property (!irq ##1 irq);

endmodule

`default_nettype wire

// File: dct_pins.sv
`timescale 1ns/1ps
`default_nettype none

module dct_pins (
  input wire logic core_clk,
  output logic pin_a_in,
  output logic pin_b_in,
  output logic trig_in
);
  // ----------
  // pins idle high, trigger idle low
  // ----------
  initial begin
    pin_a_in = 1'b1;
    pin_b_in = 1'b1;
    trig_in = 1'b0;
  end

  // which: 0 pin a, 1 pin b, 2 trigger; hold picks prompt or slow edges
  task pulse(input int which, input int hold);
    @(posedge core_clk);
    if (which == 0) pin_a_in <= 1'b0;
    else if (which == 1) pin_b_in <= 1'b0;
    else trig_in <= 1'b1;
    repeat (hold) @(posedge core_clk);
    if (which == 0) pin_a_in <= 1'b1;
    else if (which == 1) pin_b_in <= 1'b1;
    else trig_in <= 1'b0;
    repeat (hold) @(posedge core_clk);
  endtask
endmodule

`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
  import dct_pkg::*;
;
  // ----------
  // signals
  // ----------
  logic core_clk;
  logic rst_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic pin_a_in;
  logic pin_b_in;
  logic trig_in;
  logic pin_a_out;
  logic pin_a_oe_n;
  logic irq;
  int error_cnt = 0;
  int compares = 0;
  int n;
  int m;
  int i;

  dct_timer u_dct_timer (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pin_a_in, .pin_b_in, .trig_in, .pin_a_out, .pin_a_oe_n, .irq);
  dct_pins u_dct_pins (.core_clk, .pin_a_in, .pin_b_in, .trig_in);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ----------
  // tasks
  // ----------
  task stop_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string nm);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, reg_rdata, exp);
  endtask

  // length of the next full phase of pin a at level lv
  task meas(input logic lv, output int n);
    int k;
    int j;
    for (k = 0; pin_a_out === lv && k < 600; k++) @(posedge core_clk);
    for (j = 0; pin_a_out !== lv && j < 600; j++) @(posedge core_clk);
    for (n = 0; pin_a_out === lv && n < 600; n++) @(posedge core_clk);
    if (k + j + n >= 600) begin
      error_cnt++;
      stop_test();
    end
  endtask

  task pulses(output int n);
    logic p;
    n = 0;
    p = pin_a_out;
    repeat (80) begin
      @(posedge core_clk);
      if (pin_a_out === 1'b1 && p !== 1'b1) n++;
      p = pin_a_out;
    end
  endtask

  function automatic logic [31:0] cf(logic [2:0] md, logic [1:0] c1, logic [1:0] c2,
    logic [31:0] x);
    return x | {25'h000_0000, c2, c1, md};
  endfunction

  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    stop_test();
  end

  // ----------
  // sequence
  // ----------
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk("oe_n", 32'(pin_a_oe_n), 32'h0000_0001);
    chk("irq", 32'(irq), 32'h0000_0000);
    rchk(8'h40, 32'h0000_0000, "unmapped");
    wr(OFS_RCA, 32'hFFFF_0001);
    rchk(OFS_RCA, 32'h0000_0001, "rca");
    wr(OFS_RCB, 32'h0000_0001);
    $display("done regs");
    for (i = 0; i < 3; i++) begin
      wr(OFS_CNT2, 32'h0000_0003);
      wr(OFS_CTRL, cf(MODE_TRAIN, CK_CPU, CK_OFF, 32'(i) << 12));
      fork
        pulses(n);
        if (i == 0) wr(OFS_CMD, 32'h0000_0001);
        else u_dct_pins.pulse(2, 4);
      join
      chk("pulses", n, 32'h0000_0003);
    end
    rchk(OFS_ISTAT, 32'h0000_000B, "train flags");
    rchk(OFS_STAT, 32'h0000_0000, "train idle");
    wr(OFS_IMASK, 32'h0000_0008);
    #1;
    chk("irq on", 32'(irq), 32'h0000_0001);
    wr(OFS_ISTAT, 32'h0000_0008);
    #1;
    chk("irq off", 32'(irq), 32'h0000_0000);
    rchk(OFS_ISTAT, 32'h0000_0003, "sticky");
    $display("done train");
    wr(OFS_ISTAT, 32'h0000_000F);
    wr(OFS_RCA, 32'h0000_0003);
    wr(OFS_RCB, 32'h0000_0005);
    wr(OFS_PRESC, 32'h0000_0003);
    wr(OFS_CNT1, 32'h0000_0000);
    for (i = 1; i < 3; i++) begin
      wr(OFS_CTRL, cf(MODE_ALT, 2'(i), CK_OFF, 32'h0001_4000));
      meas(1'b1, n);
      meas(1'b0, m);
      chk("high", n, (i == 1) ? 32'h0000_0004 : 32'h0000_0010);
      chk("low", m, (i == 1) ? 32'h0000_0006 : 32'h0000_0018);
      chk("oe_n", 32'(pin_a_oe_n), 32'h0000_0000);
    end
    wr(OFS_CTRL, 32'h0000_0000);
    rchk(OFS_ISTAT, 32'h0000_0003, "reload flags");
    $display("done alternate");
    wr(OFS_ISTAT, 32'h0000_000F);
    wr(OFS_CNT1, 32'h0000_1234);
    wr(OFS_CTRL, cf(MODE_DCAP, CK_OFF, CK_OFF, 32'h0001_0600));
    #1;
    chk("oe_n cap", 32'(pin_a_oe_n), 32'h0000_0001);
    u_dct_pins.pulse(0, 4);
    rchk(OFS_RCA, 32'h0000_1234, "cap a");
    rchk(OFS_CNT1, 32'h0000_FFFF, "preset a");
    wr(OFS_CNT1, 32'h0000_0055);
    u_dct_pins.pulse(1, 12);
    rchk(OFS_RCB, 32'h0000_0055, "cap b");
    rchk(OFS_CNT1, 32'h0000_0055, "no preset b");
    wr(OFS_CTRL, cf(MODE_DCAP, CK_OFF, CK_OFF, 32'h0000_0A00));
    u_dct_pins.pulse(1, 4);
    rchk(OFS_CNT1, 32'h0000_FFFF, "preset b");
    rchk(OFS_ISTAT, 32'h0000_0003, "cap flags");
    wr(OFS_ISTAT, 32'h0000_000F);
    wr(OFS_CNT1, 32'h0000_0002);
    wr(OFS_CTRL, cf(MODE_DCAP, CK_CPU, CK_OFF, 32'h0000_4000));
    repeat (8) @(posedge core_clk);
    rchk(OFS_ISTAT, 32'h0000_0004, "underflow c");
    wr(OFS_CTRL, 32'h0000_0000);
    $display("done capture");
    wr(OFS_ISTAT, 32'h0000_000F);
    wr(OFS_RCA, 32'h0000_0002);
    wr(OFS_RCB, 32'h0000_0001);
    wr(OFS_CNT1, 32'h0000_0000);
    wr(OFS_CNT2, 32'h0000_0001);
    wr(OFS_CTRL, cf(MODE_DUAL, CK_CPU, CK_EXT, 32'h0001_C080));
    meas(1'b1, n);
    meas(1'b0, m);
    chk("sq high", n, 32'h0000_0003);
    chk("sq low", m, 32'h0000_0003);
    u_dct_pins.pulse(1, 4);
    rchk(OFS_ISTAT, 32'h0000_0001, "one edge");
    u_dct_pins.pulse(1, 4);
    rchk(OFS_ISTAT, 32'h0000_0009, "dual flags");
    $display("done dual");
    wr(OFS_ISTAT, 32'h0000_000F);
    wr(OFS_CNT2, 32'h0000_0ABC);
    wr(OFS_CTRL, cf(MODE_CAPT, CK_CPU, CK_OFF, 32'h0000_4800));
    u_dct_pins.pulse(1, 4);
    rchk(OFS_RCB, 32'h0000_0ABC, "capt");
    rchk(OFS_CNT2, 32'h0000_FFFF, "capt preset");
    rchk(OFS_ISTAT, 32'h0000_0003, "capt flags");
    $display("done capture timer");
    stop_test();
  end
endmodule

`default_nettype wire
